// File: core/sdac_buf2.sv
`timescale 1ns/1ps
// ***********************************
// two-entry buffer
// ***********************************
module sdac_buf2 #(
	parameter int W = 16
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic srst_i,
	// fill side
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [W-1:0] in_data_i,
	// drain side
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [W-1:0] out_data_o
);
	logic [W-1:0] mem_r [0:1];
	logic [W-1:0] mem_nxt [0:1];
	logic [1:0] cnt_r, cnt_nxt;
	logic push, pop;
	assign in_ready_o = (cnt_r != 2'h2);
	assign out_valid_o = (cnt_r != 2'h0);
	assign out_data_o = mem_r[0];
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;
	always_comb begin
		mem_nxt[0] = mem_r[0];
		mem_nxt[1] = mem_r[1];
		cnt_nxt = cnt_r;
		if (pop) begin
			mem_nxt[0] = mem_r[1];
		end
		if (push) begin
			if (cnt_r == 2'h0 || (cnt_r == 2'h1 && pop)) begin
				mem_nxt[0] = in_data_i;
			end else begin
				mem_nxt[1] = in_data_i;
			end
		end
		if (push && !pop) begin
			cnt_nxt = cnt_r + 2'h1;
		end else if (pop && !push) begin
			cnt_nxt = cnt_r - 2'h1;
		end
	end
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			cnt_r <= 2'h0;
			mem_r[0] <= '0;
			mem_r[1] <= '0;
		end else begin
			cnt_r <= cnt_nxt;
			mem_r[0] <= mem_nxt[0];
			mem_r[1] <= mem_nxt[1];
		end
	end
endmodule : sdac_buf2

// File: core/sdac_pkg.sv
package sdac_pkg;
	typedef struct packed {
		logic speed_fast;
		logic power_down;
		logic [9:0] code;
	} sdac_out_type;
	typedef enum logic [1:0] {
		SDAC_IDLE = 2'b00,
		SDAC_SHIFT = 2'b01,
		SDAC_DONE = 2'b10
	} sdac_state_type;
endpackage : sdac_pkg

// File: core/sdac_port.sv
// Notes on behaviour
// - frame sync fall starts; bits captured on serial clock falls, msb first
// - shift register moves to latch after sixteen bits or frame sync rise
// - sixteenth bit on sixteenth fall; latch update on next serial clock rise
// - shift register and latch are sixteen bits wide
// - code is unsigned ten bits; output is twice reference times code/1024
// - latches clear to zero at reset
// - four-wire with select or three-wire with select tied low
// - bit 14 picks fast settling; bits 15 and 12 ignored
// - bit 13 powers down all amplifiers
// - bits 11..2 carry the code; host sends zeros in bits 1..0
`timescale 1ns/1ps
`include "sdac_regs.svh"
module sdac_port (
	// clock and reset
	input wire logic clk_i,
	input wire logic srst_i,
	// serial pins
	input wire logic dev_sel_n_i,
	input wire logic frame_sync_n_i,
	input wire logic sclk_i,
	input wire logic sdata_i,
	// latch side
	input wire logic out_ready_i,
	output logic out_valid_o,
	output sdac_pkg::sdac_out_type dac_o,
	output logic [15:0] latch_o
);
	import sdac_pkg::*;
	// ***********************************
	// pin synchronisers
	// ***********************************
	logic [3:0] s1_r, s2_r, s3_r;
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			s1_r <= 4'hF;
			s2_r <= 4'hF;
			s3_r <= 4'hF;
		end else begin
			s1_r <= {dev_sel_n_i, frame_sync_n_i, sclk_i, sdata_i};
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end
	logic sel, fs_fall, fs_rise, ck_fall, ck_rise, din;
	// select tied low gives the three-wire mode
	assign sel = !s2_r[3];
	assign fs_fall = s3_r[2] && !s2_r[2];
	assign fs_rise = !s3_r[2] && s2_r[2];
	assign ck_fall = s3_r[1] && !s2_r[1];
	assign ck_rise = !s3_r[1] && s2_r[1];
	// data taken from the same synchroniser stage as the fall; host hold keeps it valid
	assign din = s2_r[0];
	// ***********************************
	// shifter
	// ***********************************
	sdac_state_type st_r, st_nxt;
	logic [15:0] sh_r, sh_nxt;
	logic [4:0] cnt_r, cnt_nxt;
	logic push;
	logic in_ready;
	always_comb begin
		st_nxt = st_r;
		sh_nxt = sh_r;
		cnt_nxt = cnt_r;
		push = 1'b0;
		case (st_r)
			SDAC_IDLE: begin
				if (sel && fs_fall) begin
					st_nxt = SDAC_SHIFT;
					cnt_nxt = 5'h00;
				end
			end
			SDAC_SHIFT: begin
				if (!sel) begin
					st_nxt = SDAC_IDLE;
				end else if (fs_rise && cnt_r != 5'h00) begin
					push = 1'b1;
					st_nxt = SDAC_IDLE;
				end else if (ck_fall && cnt_r < `SDAC_BITS_PER_WORD) begin
					sh_nxt = {sh_r[14:0], din};
					cnt_nxt = cnt_r + 5'h01;
				end else if (ck_rise && cnt_r == `SDAC_BITS_PER_WORD) begin
					push = 1'b1;
					st_nxt = SDAC_DONE;
				end
			end
			SDAC_DONE: begin
				if (fs_fall && sel) begin
					st_nxt = SDAC_SHIFT;
					cnt_nxt = 5'h00;
				end
			end
			default: st_nxt = SDAC_IDLE;
		endcase
	end
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			st_r <= SDAC_IDLE;
			sh_r <= `SDAC_LATCH_RST;
			cnt_r <= 5'h00;
		end else begin
			st_r <= st_nxt;
			sh_r <= sh_nxt;
			cnt_r <= cnt_nxt;
		end
	end
	// ***********************************
	// buffer and latch
	// ***********************************
	logic bvalid;
	logic [15:0] bdata;
	// a full buffer drops the word; host rate is far below drain rate
	sdac_buf2 #(.W(16)) u_buf (
		.clk_i(clk_i),
		.srst_i(srst_i),
		.in_valid_i(push),
		.in_ready_o(in_ready),
		.in_data_i(sh_r),
		.out_valid_o(bvalid),
		.out_ready_i(out_ready_i),
		.out_data_o(bdata)
	);
	logic [15:0] latch_r, latch_nxt;
	logic ov_r, ov_nxt;
	always_comb begin
		latch_nxt = latch_r;
		ov_nxt = 1'b0;
		if (bvalid && out_ready_i) begin
			latch_nxt = bdata;
			ov_nxt = 1'b1;
		end
	end
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			latch_r <= `SDAC_LATCH_RST;
			ov_r <= 1'b0;
		end else begin
			latch_r <= latch_nxt;
			ov_r <= ov_nxt;
		end
	end
	assign out_valid_o = ov_r;
	assign latch_o = latch_r;
	assign dac_o.speed_fast = latch_r[`SDAC_BIT_SPEED];
	assign dac_o.power_down = latch_r[`SDAC_BIT_PWR];
	// unsigned code, analog scaling is outside
	assign dac_o.code = latch_r[`SDAC_CODE_MSB:`SDAC_CODE_LSB];
	// ***********************************
	// checks
	// ***********************************
	a_word_update: assert property (@(posedge clk_i) disable iff (srst_i)
		(st_r == SDAC_SHIFT && ck_rise && cnt_r == 5'h10 && sel && !fs_rise)
		|=> st_r == SDAC_DONE) else $error("no update after 16 bits");
	a_early_fs: assert property (@(posedge clk_i) disable iff (srst_i)
		(st_r == SDAC_SHIFT && sel && fs_rise && cnt_r != 5'h00)
		|=> st_r == SDAC_IDLE) else $error("fs rise no update");
	a_shift_msb: assert property (@(posedge clk_i) disable iff (srst_i)
		(st_r == SDAC_SHIFT && sel && !fs_rise && ck_fall && cnt_r < 5'h10)
		|=> sh_r[0] == $past(din) && cnt_r == $past(cnt_r) + 5'h01)
		else $error("bad shift");
	a_done_hold: assert property (@(posedge clk_i) disable iff (srst_i)
		(st_r == SDAC_DONE && !fs_fall) |=> $stable(sh_r))
		else $error("shift after update");
	a_latch_path: assert property (@(posedge clk_i) disable iff (srst_i)
		(bvalid && out_ready_i) |=> latch_r == $past(bdata) && ov_r)
		else $error("latch not loaded");
	a_speed_map: assert property (@(posedge clk_i) disable iff (srst_i)
		dac_o.speed_fast == latch_r[14]) else $error("speed bit");
	a_pwr_map: assert property (@(posedge clk_i) disable iff (srst_i)
		dac_o.power_down == latch_r[13]) else $error("power bit");
	a_reset_clr: assert property (@(posedge clk_i)
		srst_i |=> latch_r == 16'h0000 && st_r == SDAC_IDLE)
		else $error("reset not clear");
	a_desel_idle: assert property (@(posedge clk_i) disable iff (srst_i)
		(st_r == SDAC_SHIFT && !sel) |=> st_r == SDAC_IDLE)
		else $error("deselect ignored");
endmodule : sdac_port

// File: core/sdac_regs.svh
`ifndef SDAC_REGS_SVH
`define SDAC_REGS_SVH
// word layout
`define SDAC_WORD_W 16
`define SDAC_CODE_W 10
`define SDAC_BIT_SPEED 14
`define SDAC_BIT_PWR 13
`define SDAC_CODE_MSB 11
`define SDAC_CODE_LSB 2
`define SDAC_BITS_PER_WORD 5'h10
`define SDAC_LATCH_RST 16'h0000
`endif

// File: verif/sdac_host_model.sv
`timescale 1ns/1ps
// ****
// host serial port, sclk idles high between frames
// ****
module sdac_host_model (
	// clock
	input wire logic clk_i,
	// serial pins
	output logic sel_n_o,
	output logic fs_n_o,
	output logic sclk_o,
	output logic sdata_o
);
	initial begin
		sel_n_o = 1'b1;
		fs_n_o = 1'b1;
		sclk_o = 1'b1;
		sdata_o = 1'b0;
	end
	// half of a 400 ns sclk period
	task automatic half;
		repeat (4) @(negedge clk_i);
	endtask : half
	task automatic send(input logic [15:0] w, input int n, input logic sel);
		sel_n_o = sel;
		half();
		fs_n_o = 1'b0;
		for (int i = 0; i < n; i++) begin
			sdata_o = (i < 16) ? w[15 - i] : ~sdata_o;
			half();
			sclk_o = 1'b0;
			half();
			sclk_o = 1'b1;
		end
		half();
		fs_n_o = 1'b1;
		// stale data would hide a late sample
		sdata_o = ~sdata_o;
		half();
	endtask : send
	// select drops mid-frame, so no update may follow
	task automatic abort(input logic [15:0] w, input int n);
		sel_n_o = 1'b0;
		half();
		fs_n_o = 1'b0;
		for (int i = 0; i < n; i++) begin
			sdata_o = w[15 - i];
			half();
			sclk_o = 1'b0;
			half();
			sclk_o = 1'b1;
		end
		half();
		sel_n_o = 1'b1;
		half();
		fs_n_o = 1'b1;
		half();
	endtask : abort
endmodule : sdac_host_model

// File: verif/serial_dac_input_port_tb.sv
`timescale 1ns/1ps
module serial_dac_input_port_tb;
	import sdac_pkg::*;
	// ****
	// pins and capture
	// ****
	logic clk_i = 1'b0;
	logic srst_i = 1'b1;
	logic out_ready_i = 1'b1;
	logic sel_n, fs_n, sclk, sdata, out_valid;
	sdac_out_type dac;
	logic [15:0] latch;
	logic [15:0] got[$];
	int miscompares = 0;
	int checks_done = 0;
	initial forever #25 clk_i = ~clk_i;
	sdac_host_model host (.clk_i(clk_i), .sel_n_o(sel_n), .fs_n_o(fs_n),
		.sclk_o(sclk), .sdata_o(sdata));
	sdac_port uut (.clk_i(clk_i), .srst_i(srst_i), .dev_sel_n_i(sel_n),
		.frame_sync_n_i(fs_n), .sclk_i(sclk), .sdata_i(sdata),
		.out_ready_i(out_ready_i), .out_valid_o(out_valid), .dac_o(dac),
		.latch_o(latch));
	// pulse lasts one cycle, so every update lands here
	always @(posedge clk_i) begin
		if (out_valid === 1'b1) begin
			got.push_back(latch);
		end
	end
	// ****
	// helpers
	// ****
	task automatic check(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic take(input logic [15:0] exp);
		// an early frame sync update lands after send returns
		repeat (4) @(negedge clk_i);
		check("count", 16'(got.size()), 16'h0001);
		check("latch", got.pop_front(), exp);
	endtask : take
	task automatic print_verdict;
		$display("checks %0d miscompares %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : print_verdict
	// ****
	// scenarios
	// ****
	task automatic t_words;
		logic [15:0] w [3] = '{16'h4FFC, 16'hB000, 16'h2A54};
		for (int i = 0; i < 3; i++) begin
			host.send(w[i], 16, 1'b0);
			take(w[i]);
			check("dac", {4'h0, dac}, {4'h0, w[i][14:13], w[i][11:2]});
		end
	endtask : t_words
	task automatic t_early;
		// shifter is not cleared, old low byte moves up
		host.send(16'hA500, 8, 1'b0);
		take(16'h54A5);
	endtask : t_early
	task automatic t_extra;
		host.send(16'h1230, 20, 1'b0);
		take(16'h1230);
	endtask : t_extra
	task automatic t_sel;
		host.send(16'h5550, 16, 1'b1);
		check("count", 16'(got.size()), 16'h0000);
		check("kept", latch, 16'h1230);
		host.abort(16'h7770, 8);
		repeat (4) @(negedge clk_i);
		check("abort", 16'(got.size()), 16'h0000);
		check("abort kept", latch, 16'h1230);
	endtask : t_sel
	task automatic t_buffer;
		out_ready_i = 1'b0;
		host.send(16'h1110, 16, 1'b0);
		host.send(16'h2220, 16, 1'b0);
		host.send(16'h3330, 16, 1'b0);
		check("held", 16'(got.size()), 16'h0000);
		out_ready_i = 1'b1;
		repeat (10) @(negedge clk_i);
		check("count", 16'(got.size()), 16'h0002);
		check("first", got.pop_front(), 16'h1110);
		check("second", got.pop_front(), 16'h2220);
	endtask : t_buffer
	initial begin
		repeat (6) @(negedge clk_i);
		srst_i = 1'b0;
		check("rst latch", latch, 16'h0000);
		check("rst dac", {4'h0, dac}, 16'h0000);
		t_words();
		t_early();
		t_extra();
		t_sel();
		t_buffer();
		print_verdict();
	end
endmodule : serial_dac_input_port_tb
